/* core/vio_pkg.sv */
// constants shared by the valve and digital i/o test controller
// Summary of operation
// - valve on means its coil energised
// - on three-way valve selects normally-closed port
// - sequencing off: software switches each fitted valve
// - sequencing on: instrument control drives every fitted valve
// - sequencing off: valves change only by command
// - sample valve: off sample inlet, on cal
// - zero valve: off background air, on cal
// - optional pressurised valves: own outputs, readable
// - input test reports eight input levels
// - test mode suspends normal analog/digital i/o
// - leaving test mode restores automatic i/o control
// - automated output test sweeps every output
// - pump manual flow control clears valve sequencing
package vio_pkg;
	// register byte offsets
	localparam logic [7:0] VIO_OFS_CTRL = 8'h00;
	localparam logic [7:0] VIO_OFS_VALVE_MAN = 8'h04;
	localparam logic [7:0] VIO_OFS_VALVE_STAT = 8'h08;
	localparam logic [7:0] VIO_OFS_DIN = 8'h0C;
	localparam logic [7:0] VIO_OFS_DOUT = 8'h10;
	localparam logic [7:0] VIO_OFS_HOLD = 8'h14;
	localparam logic [7:0] VIO_OFS_STATUS = 8'h18;
	// control register fields
	localparam int VIO_CTRL_SEQ_BIT = 0;
	localparam int VIO_CTRL_PUMP_BIT = 1;
	localparam int VIO_CTRL_MODE_LSB = 2;
	localparam int VIO_CTRL_START_BIT = 4;
	// valve indices
	localparam int VIO_V_SAMPLE = 0;
	localparam int VIO_V_ZERO = 1;
	localparam int VIO_V_PZERO = 2;
	localparam int VIO_V_PSPAN = 3;
	localparam int VIO_NUM_VALVES = 4;
	localparam int VIO_NUM_IO = 8;
	// test mode encoding
	localparam logic [1:0] VIO_MODE_NONE = 2'h0;
	localparam logic [1:0] VIO_MODE_DIN = 2'h1;
	localparam logic [1:0] VIO_MODE_DOUT = 2'h2;
	// reset values
	localparam logic VIO_SEQ_RST = 1'h1;
	localparam logic [3:0] VIO_VALVE_RST = 4'h0;
	localparam logic [7:0] VIO_DOUT_RST = 8'h00;
	localparam logic [15:0] VIO_HOLD_RST = 16'h0100;
	localparam logic [2:0] VIO_IDX_LAST = 3'h7;
endpackage : vio_pkg

/* core/vio_sweep_if.sv */
// carrier between the register front end and the output sweep engine
`timescale 1ns/1ps
interface vio_sweep_if;
	logic start;
	logic abort;
	logic [15:0] hold;
	logic busy;
	logic [2:0] idx;
	logic [7:0] pattern;
	modport ctl (
		output start,
		output abort,
		output hold,
		input busy,
		input idx,
		input pattern
	);
	modport eng (
		input start,
		input abort,
		input hold,
		output busy,
		output idx,
		output pattern
	);
endinterface : vio_sweep_if

/* core/vio_sweep.sv */
// automated digital output sweep engine
`timescale 1ns/1ps
module vio_sweep
	import vio_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	vio_sweep_if.eng sw
);
	typedef enum logic [2:0] {
		VIO_SW_IDLE = 3'b001,
		VIO_SW_ON = 3'b010,
		VIO_SW_OFF = 3'b100
	} vio_sweep_state_t;

	vio_sweep_state_t state_r;
	logic [15:0] cnt_r;
	logic [2:0] idx_r;
	logic [15:0] load;

	// a zero hold would wrap to the longest count, so it is treated as one cycle
	assign load = (sw.hold == 16'h0000) ? 16'h0000 : sw.hold - 16'h0001;

	// on phase then equal off phase per output, lowest index first
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= VIO_SW_IDLE;
			cnt_r <= 16'h0000;
			idx_r <= 3'h0;
		end else if (sw.abort) begin
			state_r <= VIO_SW_IDLE;
			cnt_r <= 16'h0000;
			idx_r <= 3'h0;
		end else begin
			case (state_r)
				VIO_SW_IDLE: begin
					if (sw.start) begin
						state_r <= VIO_SW_ON;
						idx_r <= 3'h0;
						cnt_r <= load;
					end
				end
				VIO_SW_ON: begin
					if (cnt_r == 16'h0000) begin
						state_r <= VIO_SW_OFF;
						cnt_r <= load;
					end else begin
						cnt_r <= cnt_r - 16'h0001;
					end
				end
				VIO_SW_OFF: begin
					if (cnt_r != 16'h0000) begin
						cnt_r <= cnt_r - 16'h0001;
					end else if (idx_r == VIO_IDX_LAST) begin
						state_r <= VIO_SW_IDLE;
					end else begin
						state_r <= VIO_SW_ON;
						idx_r <= idx_r + 3'h1;
						cnt_r <= load;
					end
				end
				default: begin
					state_r <= VIO_SW_IDLE;
				end
			endcase
		end
	end

	assign sw.busy = (state_r != VIO_SW_IDLE);
	assign sw.idx = idx_r;
	// only the visited output is driven, and only in its on phase
	assign sw.pattern = (state_r == VIO_SW_ON) ? (8'h01 << idx_r) : 8'h00;
endmodule : vio_sweep

/* core/vio_top.sv */
// valve sequencing and digital i/o test controller top level
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module vio_top
	import vio_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// instrument automatic control, same clock
	input wire logic [3:0] auto_valve,
	input wire logic [7:0] auto_dout,
	// pins
	input wire logic [7:0] din_pin,
	input wire logic [1:0] opt_fitted_pin,
	output logic [3:0] valve_coil,
	output logic sample_src_cal,
	output logic zero_src_cal,
	output logic [7:0] dout_pin,
	output logic io_suspend
);
	// synchronisers for pins from outside the clock domain
	logic [7:0] din_meta_r;
	logic [7:0] din_sync_r;
	logic [1:0] opt_meta_r;
	logic [1:0] opt_sync_r;

	// software state
	logic seq_en_r;
	logic pump_manual_r;
	logic [1:0] test_mode_r;
	logic [3:0] valve_man_r;
	logic [7:0] dout_man_r;
	logic [15:0] hold_r;
	logic start_r;
	logic [1:0] mode_prev_r;

	// output registers
	logic [3:0] valve_coil_r;
	logic sample_src_cal_r;
	logic zero_src_cal_r;
	logic [7:0] dout_r;
	logic io_suspend_r;
	logic [31:0] rdata_r;

	// decode helpers
	logic wr_ctrl;
	logic wr_valve;
	logic wr_dout;
	logic wr_hold;
	logic in_din_test;
	logic in_dout_test;
	logic test_active;
	logic [1:0] mode_wr;
	logic [3:0] valve_fit_mask;
	logic [3:0] valve_want;
	logic [7:0] dout_nxt;
	logic [31:0] rdata_nxt;

	vio_sweep_if sw_if ();

	vio_sweep u_sweep (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.sw(sw_if.eng)
	);

	// write strobes per register
	assign wr_ctrl = reg_wr && (reg_addr == VIO_OFS_CTRL);
	assign wr_valve = reg_wr && (reg_addr == VIO_OFS_VALVE_MAN);
	assign wr_dout = reg_wr && (reg_addr == VIO_OFS_DOUT);
	assign wr_hold = reg_wr && (reg_addr == VIO_OFS_HOLD);
	assign mode_wr = reg_wdata[VIO_CTRL_MODE_LSB +: 2];

	// mode code 3 is reserved and behaves as no test
	assign in_din_test = (test_mode_r == VIO_MODE_DIN);
	assign in_dout_test = (test_mode_r == VIO_MODE_DOUT);
	assign test_active = in_din_test || in_dout_test;

	// two flops before anything looks at a pin
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			din_meta_r <= 8'h00;
			din_sync_r <= 8'h00;
			opt_meta_r <= 2'h0;
			opt_sync_r <= 2'h0;
		end else begin
			din_meta_r <= din_pin;
			din_sync_r <= din_meta_r;
			opt_meta_r <= opt_fitted_pin;
			opt_sync_r <= opt_meta_r;
		end
	end

	// valve sequencing enable and pump flow control selection
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			seq_en_r <= VIO_SEQ_RST;
			pump_manual_r <= 1'h0;
		end else if (wr_ctrl) begin
			pump_manual_r <= reg_wdata[VIO_CTRL_PUMP_BIT];
			// choosing manual flow overrides an enable in the same write
			if (reg_wdata[VIO_CTRL_PUMP_BIT] && !pump_manual_r) begin
				seq_en_r <= 1'h0;
			end else begin
				seq_en_r <= reg_wdata[VIO_CTRL_SEQ_BIT];
			end
		end
	end

	// test mode selection and edge tracking
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			test_mode_r <= VIO_MODE_NONE;
			mode_prev_r <= VIO_MODE_NONE;
		end else begin
			mode_prev_r <= test_mode_r;
			if (wr_ctrl) begin
				test_mode_r <= mode_wr;
			end
		end
	end

	// sweep start is a write-one pulse, honoured only in output test
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			start_r <= 1'h0;
		end else begin
			start_r <= wr_ctrl && reg_wdata[VIO_CTRL_START_BIT] && in_dout_test
				&& (mode_wr == VIO_MODE_DOUT);
		end
	end

	// sweep hold interval, in clock cycles
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hold_r <= VIO_HOLD_RST;
		end else if (wr_hold) begin
			hold_r <= reg_wdata[15:0];
		end
	end

	assign sw_if.start = start_r;
	// leaving output test stops a sweep in progress
	assign sw_if.abort = !in_dout_test;
	assign sw_if.hold = hold_r;

	// manual valve image: tracks the controller while sequencing is on,
	// so turning sequencing off leaves every valve where it was
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			valve_man_r <= VIO_VALVE_RST;
		end else if (seq_en_r) begin
			valve_man_r <= auto_valve;
		end else if (wr_valve) begin
			valve_man_r <= reg_wdata[3:0];
		end
	end

	// optional valves that are not fitted are held de-energised
	assign valve_fit_mask = {opt_sync_r[1], opt_sync_r[0], 1'b1, 1'b1};

	// source of each coil: controller when sequencing, else manual image
	assign valve_want = (seq_en_r ? auto_valve : valve_man_r) & valve_fit_mask;

	// coil drive and flow path selects
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			valve_coil_r <= VIO_VALVE_RST;
			sample_src_cal_r <= 1'h0;
			zero_src_cal_r <= 1'h0;
		end else begin
			valve_coil_r <= valve_want;
			// on puts the three-way valve in its normally-closed path
			sample_src_cal_r <= valve_want[VIO_V_SAMPLE];
			zero_src_cal_r <= valve_want[VIO_V_ZERO];
		end
	end

	// manual output pattern for output test mode
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dout_man_r <= VIO_DOUT_RST;
		end else if (wr_dout && in_dout_test && !sw_if.busy) begin
			dout_man_r <= reg_wdata[7:0];
		end else if (test_mode_r != mode_prev_r) begin
			// each entry to output test starts with all outputs off
			dout_man_r <= VIO_DOUT_RST;
		end
	end

	// per-output selection between automatic, sweep and manual drive
	genvar gi;
	generate
		for (gi = 0; gi < VIO_NUM_IO; gi++) begin : g_dout
			always_comb begin
				if (in_dout_test) begin
					dout_nxt[gi] = sw_if.busy ? sw_if.pattern[gi] : dout_man_r[gi];
				end else if (in_din_test) begin
					dout_nxt[gi] = 1'b0;
				end else begin
					dout_nxt[gi] = auto_dout[gi];
				end
			end
		end
	endgenerate

	// digital outputs and suspend flag toward the analog side
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dout_r <= VIO_DOUT_RST;
			io_suspend_r <= 1'h0;
		end else begin
			dout_r <= dout_nxt;
			io_suspend_r <= test_active;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		case (reg_addr)
			VIO_OFS_CTRL: begin
				rdata_nxt[VIO_CTRL_SEQ_BIT] = seq_en_r;
				rdata_nxt[VIO_CTRL_PUMP_BIT] = pump_manual_r;
				rdata_nxt[VIO_CTRL_MODE_LSB +: 2] = test_mode_r;
			end
			VIO_OFS_VALVE_MAN: begin
				rdata_nxt[3:0] = valve_man_r;
			end
			VIO_OFS_VALVE_STAT: begin
				rdata_nxt[3:0] = valve_coil_r;
				rdata_nxt[5:4] = opt_sync_r;
			end
			VIO_OFS_DIN: begin
				// levels are only meaningful to software in input test
				rdata_nxt[7:0] = in_din_test ? din_sync_r : 8'h00;
			end
			VIO_OFS_DOUT: begin
				rdata_nxt[7:0] = dout_r;
			end
			VIO_OFS_HOLD: begin
				rdata_nxt[15:0] = hold_r;
			end
			VIO_OFS_STATUS: begin
				rdata_nxt[0] = sw_if.busy;
				rdata_nxt[3:1] = sw_if.idx;
				rdata_nxt[4] = test_active;
			end
			default: begin
				rdata_nxt = 32'h0000_0000;
			end
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r <= 32'h0000_0000;
		end else if (reg_rd) begin
			rdata_r <= rdata_nxt;
		end else begin
			rdata_r <= 32'h0000_0000;
		end
	end

	assign reg_rdata = rdata_r;
	assign valve_coil = valve_coil_r;
	assign sample_src_cal = sample_src_cal_r;
	assign zero_src_cal = zero_src_cal_r;
	assign dout_pin = dout_r;
	assign io_suspend = io_suspend_r;
endmodule : vio_top

/* tb/vio_pins_model.sv */
// far side pins: digital input lines and option straps
`timescale 1ns/1ps
module vio_pins_model #(
	parameter logic [1:0] FITTED = 2'h1
) (
	input wire logic core_clk,
	input wire logic [7:0] din_req,
	output logic [7:0] din_pin,
	output logic [1:0] opt_fitted_pin
);
	// straps are wired at build time, so they never move
	assign opt_fitted_pin = FITTED;
	// field wires switch off the clock edge; the device must sync them
	initial din_pin = 8'h00;
	always @(posedge core_clk) din_pin <= #1.3 din_req;
endmodule : vio_pins_model

/* tb/vio_properties.sv */
// port assertions for the valve and digital i/o controller
`timescale 1ns/1ps
module vio_properties
	import vio_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [3:0] auto_valve,
	input wire logic [7:0] auto_dout,
	input wire logic [1:0] opt_fitted_pin,
	input wire logic [3:0] valve_coil,
	input wire logic sample_src_cal,
	input wire logic zero_src_cal,
	input wire logic [7:0] dout_pin,
	input wire logic io_suspend
);
	logic seq_r, pump_r, tst, man_w;
	logic [1:0] mode_r;
	logic [15:0] hold_r;
	assign man_w = reg_wr && reg_addr == VIO_OFS_VALVE_MAN;
	assign tst = mode_r == VIO_MODE_DIN || mode_r == VIO_MODE_DOUT;
	// shadow of control fields, decoded from writes only
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			seq_r <= VIO_SEQ_RST;
			pump_r <= 1'b0;
			mode_r <= VIO_MODE_NONE;
		end else if (reg_wr && reg_addr == VIO_OFS_CTRL) begin
			seq_r <= reg_wdata[0] && !(reg_wdata[1] && !pump_r);
			pump_r <= reg_wdata[1];
			mode_r <= reg_wdata[3:2];
		end
	end
	// hold shadow gates the sweep timing check
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hold_r <= VIO_HOLD_RST;
		end else if (reg_wr && reg_addr == VIO_OFS_HOLD) begin
			hold_r <= reg_wdata[15:0];
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_lit;
		(dout_pin == 8'h01) [*2];
	endsequence
	sequence s_dark;
		(dout_pin == 8'h00) [*2];
	endsequence
	a_sample_path: assert property (sample_src_cal == valve_coil[VIO_V_SAMPLE])
		else $error("sample path differs from coil");
	a_zero_path: assert property (zero_src_cal == valve_coil[VIO_V_ZERO])
		else $error("zero path differs from coil");
	a_seq_follow: assert property (!$past(sys_rst) && seq_r && $past(seq_r)
		|-> valve_coil[1:0] == $past(auto_valve[1:0])) else $error("coil ignores auto");
	a_man_hold: assert property (!$past(sys_rst) && !seq_r && !$past(seq_r) &&
		!$past(seq_r, 2) && !$past(man_w, 2) |-> $stable(valve_coil))
		else $error("coil moved without command");
	a_unfit_off: assert property (!opt_fitted_pin[1] && !$past(opt_fitted_pin[1], 3)
		|-> !valve_coil[VIO_V_PSPAN]) else $error("unfitted valve driven");
	a_din_quiet: assert property (!$past(sys_rst) && mode_r == VIO_MODE_DIN &&
		$past(mode_r) == VIO_MODE_DIN |-> dout_pin == 8'h00) else $error("outputs live");
	a_suspend_flag: assert property (!$past(sys_rst) && mode_r == $past(mode_r)
		|-> io_suspend == tst) else $error("suspend flag wrong");
	a_auto_restore: assert property (!$past(sys_rst) && !tst && !$past(tst)
		|-> dout_pin == $past(auto_dout)) else $error("outputs not automatic");
	// outputs lag the mode by one cycle, so the previous mode must be output test too
	a_sweep_step: assert property (mode_r == VIO_MODE_DOUT && hold_r == 16'h0002 &&
		$past(mode_r) == VIO_MODE_DOUT && $rose(dout_pin[0])
		|-> s_lit ##1 s_dark ##1 dout_pin == 8'h02)
		else $error("sweep step wrong");
endmodule : vio_properties
bind vio_top vio_properties u_props (.core_clk(core_clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .auto_valve(auto_valve),
	.auto_dout(auto_dout), .opt_fitted_pin(opt_fitted_pin), .valve_coil(valve_coil),
	.sample_src_cal(sample_src_cal), .zero_src_cal(zero_src_cal), .dout_pin(dout_pin),
	.io_suspend(io_suspend));

/* tb/valve_and_io_test_control_bench.sv */
// self-checking bench for the valve and digital i/o controller
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin failures++; \
	$display("mismatch %s exp %h got %h", n, e, s); end end
module valve_and_io_test_control_bench
	import vio_pkg::*;
;
	localparam logic [1:0] FIT = 2'h1;
	localparam int HOLD = 2;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [3:0] auto_valve = 4'h0;
	logic [7:0] auto_dout = 8'h00;
	logic [7:0] din_req = 8'h00;
	logic [31:0] reg_rdata;
	logic [7:0] din_pin, dout_pin, prev, x;
	logic [1:0] opt_fitted_pin;
	logic [3:0] valve_coil, v;
	logic sample_src_cal, zero_src_cal, io_suspend;
	int failures = 0;
	int tests_run = 0;
	int cyc = 0;
	int n;
	vio_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.auto_valve(auto_valve), .auto_dout(auto_dout), .din_pin(din_pin),
		.opt_fitted_pin(opt_fitted_pin), .valve_coil(valve_coil),
		.sample_src_cal(sample_src_cal), .zero_src_cal(zero_src_cal),
		.dout_pin(dout_pin), .io_suspend(io_suspend));
	vio_pins_model #(.FITTED(FIT)) u_pins (.core_clk(core_clk), .din_req(din_req),
		.din_pin(din_pin), .opt_fitted_pin(opt_fitted_pin));
	always #2.5 core_clk = ~core_clk;
	// busy controller traffic every cycle, plus a hang limit
	always @(posedge core_clk) begin
		prev <= auto_dout;
		auto_dout <= 8'($urandom);
		cyc++;
		if (cyc == 5000) begin
			failures++;
			summarize();
		end
	end
	function automatic logic [3:0] coil_exp(input logic [3:0] a);
		return a & {FIT, 2'b11};
	endfunction : coil_exp
	function automatic logic [7:0] sw_exp(input int k);
		return ((k / HOLD) % 2 == 0) ? 8'h01 << (k / (2 * HOLD)) : 8'h00;
	endfunction : sw_exp
	task automatic tick(input int c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK("reg_rdata", e, reg_rdata)
	endtask : rd
	task automatic summarize();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize
	initial begin
		void'($urandom(32'h6d307f17));
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(VIO_OFS_CTRL, 32'h1);
		rd(VIO_OFS_HOLD, 32'h100);
		rd(8'h1C, 32'h0);
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk) auto_valve <= (i == 0) ? 4'hF : 4'($urandom);
			tick(3);
			v = coil_exp(auto_valve);
			`CHK("coil", v, valve_coil)
			`CHK("sample_src", v[0], sample_src_cal)
			rd(VIO_OFS_VALVE_STAT, {26'h0, FIT, v});
		end
		// sequencing off: controller changes must not reach the coils
		wr(VIO_OFS_CTRL, 32'h0);
		for (int i = 0; i < 3; i++) begin
			@(posedge core_clk) auto_valve <= 4'($urandom);
			tick(3);
			`CHK("coil frozen", v, valve_coil)
			x = 8'($urandom);
			wr(VIO_OFS_VALVE_MAN, {28'h0, x[3:0]});
			tick(2);
			v = coil_exp(x[3:0]);
			`CHK("coil manual", v, valve_coil)
			`CHK("zero_src", v[1], zero_src_cal)
		end
		wr(VIO_OFS_CTRL, 32'h1);
		tick(3);
		`CHK("coil override", coil_exp(auto_valve), valve_coil)
		wr(VIO_OFS_CTRL, 32'h3);
		rd(VIO_OFS_CTRL, 32'h2);
		wr(VIO_OFS_CTRL, 32'h1);
		// input test with both extreme patterns first
		wr(VIO_OFS_CTRL, 32'h5);
		tick(2);
		`CHK("suspend", 1'b1, io_suspend)
		`CHK("dout quiet", 8'h00, dout_pin)
		for (int i = 0; i < 3; i++) begin
			x = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			@(posedge core_clk) din_req <= x;
			tick(4);
			rd(VIO_OFS_DIN, {24'h0, x});
		end
		wr(VIO_OFS_CTRL, 32'h1);
		tick(2);
		`CHK("suspend off", 1'b0, io_suspend)
		`CHK("dout auto", prev, dout_pin)
		rd(VIO_OFS_DIN, 32'h0);
		// output test: manual pattern, then a full sweep, then an abort
		wr(VIO_OFS_CTRL, 32'h9);
		rd(VIO_OFS_STATUS, 32'h10);
		x = 8'($urandom) & 8'hFE;
		wr(VIO_OFS_DOUT, {24'h0, x});
		tick(2);
		`CHK("dout manual", x, dout_pin)
		rd(VIO_OFS_DOUT, {24'h0, x});
		wr(VIO_OFS_HOLD, HOLD);
		wr(VIO_OFS_CTRL, 32'h19);
		for (n = 0; n < 20 && dout_pin !== 8'h01; n++) tick(1);
		for (int k = 0; k < 16 * HOLD; k++) begin
			`CHK("sweep", sw_exp(k), dout_pin)
			tick(1);
		end
		wr(VIO_OFS_CTRL, 32'h19);
		tick(6);
		wr(VIO_OFS_CTRL, 32'h1);
		tick(2);
		`CHK("abort auto", prev, dout_pin)
		summarize();
	end
endmodule : valve_and_io_test_control_bench
